// ==== hw/sdm_pkg.sv ====
// shared constants, register map and carrier types of the door and enabling-switch monitor
// assumes one 100 MHz clock domain and a classic wishbone register bus
package sdm_pkg;

   // register byte offsets
   localparam logic [3:0] ADDR_CTRL  = 4'h0;
   localparam logic [3:0] ADDR_STAT  = 4'h4;
   localparam logic [3:0] ADDR_MASK  = 4'h8;
   localparam logic [3:0] ADDR_STATE = 4'hc;

   // control field layout
   localparam int         CFG_W        = 3;
   localparam int         CFG_DOOR_LSB = 0;
   localparam int         CFG_ESM_LSB  = 4;
   localparam logic [2:0] CFG_RST      = 3'h0;

   // event bits, shared by status and mask
   localparam int         EV_W       = 3;
   localparam int         EV_DOOR    = 0;
   localparam int         EV_ESM     = 1;
   localparam int         EV_RESET   = 2;
   localparam logic [2:0] MASK_RST   = 3'h0;

   // state register layout
   localparam int STATE_PHASE_LSB = 0;
   localparam int STATE_DFLT      = 4;
   localparam int STATE_EFLT      = 5;
   localparam int STATE_UNLOCK    = 6;
   localparam int STATE_STOP      = 7;
   localparam int STATE_CFGOK     = 8;

   // channel type of a safety input
   typedef enum logic [2:0] {
      chan_not_used   = 3'h0,
      chan_dual_eq    = 3'h1,
      chan_dual_eq_3s = 3'h2,
      chan_dual_cp    = 3'h3,
      chan_dual_cp_3s = 3'h4,
      chan_solid_3s   = 3'h5,
      chan_single     = 3'h6
   } sdm_chan_cfg_t;

   // monitoring phase, one-hot
   typedef enum logic [3:0] {
      ph_inactive = 4'h1,
      ph_delay    = 4'h2,
      ph_armed    = 4'h4,
      ph_opened   = 4'h8
   } sdm_phase_t;

   typedef struct packed {
      logic door_closed_input;
      logic enabling_switch_input;
      logic speed_limit_request_input;
      logic safe_stop_input;
   } sdm_pins_t;

   // idle pin levels: door closed, switch off, request on, stop input off
   localparam sdm_pins_t PINS_RST = 4'ha;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [3:0]  adr;
      logic [31:0] dat;
   } sdm_wb_req_t;

   typedef struct packed {
      sdm_phase_t    phase;
      sdm_pins_t     prev;
      logic          door_flt;
      logic          esm_flt;
      logic          unlock;
      sdm_chan_cfg_t door_cfg;
      sdm_chan_cfg_t esm_cfg;
      logic [2:0]    stat;
      logic [2:0]    mask;
      logic          ack;
      logic [31:0]   rdata;
   } sdm_state_t;

endpackage

// ==== hw/sdm_sync.sv ====
// two-stage synchroniser for a group of asynchronous pins
// assumes the pins are already debounced and channel-checked upstream
`timescale 1ns/1ns
module sdm_sync #(
   parameter int               WIDTH   = 4,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;

   // a zero-width group cannot be synchronised
   if (WIDTH < 1) begin : g_bad_width
      $error("sdm_sync width must be at least one");
   end

   // meta feeds only the second stage
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta     <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end
endmodule // sdm_sync

// ==== hw/sdm_monitor.sv ====
// limited-speed door and enabling-switch supervision with wishbone registers
// assumes speed compare, delay timing and stop sequencing live in neighbour logic
// How it works
// (R1) in this mode run speed and stop checks plus door and switch supervision
// (R2) unlock the door only while monitoring, switch on and speed below limit
// (R3) switch going off after the door opened raises a switch fault and stop
// (R4) door opening while switch off during monitoring raises a door fault
// (R5) during monitoring the switch is ignored until the door is first seen open
// (R6) once opened, switch supervision continues even when the door closes again
// (R7) monitoring inactive: door must stay closed, switch is don't-care
// (R8) during the monitor delay the switch has no effect
// (R9) during the monitor delay the door must stay closed or a door fault occurs
// (R10) stop reset with the door open gives a door fault
// (R11) limited-speed reset with the door open gives a door fault
// (R12) stop reset while speed request is off gives a switch fault
// (R13) door input channel type selectable, not used by default, must be used
// (R14) switch input channel type selectable, not used by default, must be used
// (R15) operator drops the speed request and keeps speed below limit after delay
// (R16) operator holds switch until door closed and request on, resets, releases
// (R17) faults latch and keep the stop in force until a valid reset
`timescale 1ns/1ns
module sdm_monitor
   import sdm_pkg::*;
(
   input  wire logic                 clock,
   input  wire logic                 rst_n,
   input  wire sdm_pkg::sdm_pins_t   pins,
   input  wire logic                 sls_active,
   input  wire logic                 sls_delay,
   input  wire logic                 speed_below_limit,
   input  wire sdm_pkg::sdm_wb_req_t wb_req,
   output logic                      wb_ack,
   output logic      [31:0]          wb_dat_o,
   output logic                      door_unlock,
   output logic                      stop_request,
   output logic                      door_fault,
   output logic                      enabling_switch_fault,
   output logic                      irq
);
   import sdm_pkg::*;

   sdm_state_t s;
   sdm_state_t next_s;
   sdm_pins_t  syn;

   logic       cfg_ok;
   logic       door_fall;
   logic       esm_fall;
   logic       ss_rise;
   logic       sls_rise;
   logic       door_ev;
   logic       esm_ev;
   logic       reset_ok;
   logic       bus_go;
   logic [2:0] ev_vec;
   sdm_phase_t phase_in;

   // pins cross into the clock domain before anything looks at them
   // sync starts at the idle levels so no false door fault or edge follows reset
   sdm_sync #(
      .WIDTH   ($bits(sdm_pins_t)),
      .RST_VAL (PINS_RST)
   ) u_sync (
      .clock    (clock),
      .rst_n    (rst_n),
      .async_in (pins),
      .sync_out (syn)
   );

   // both inputs must name a used channel type; an out-of-range code is refused too
   assign cfg_ok = (s.door_cfg != chan_not_used) && (s.door_cfg <= chan_single) &&
                   (s.esm_cfg != chan_not_used) && (s.esm_cfg <= chan_single); // [R13] [R14]

   assign door_fall = s.prev.door_closed_input && !syn.door_closed_input;
   assign esm_fall  = s.prev.enabling_switch_input && !syn.enabling_switch_input;
   assign ss_rise   = !s.prev.safe_stop_input && syn.safe_stop_input;
   assign sls_rise  = !s.prev.speed_limit_request_input && syn.speed_limit_request_input;
   assign bus_go    = wb_req.cyc && wb_req.stb && !s.ack;

   // phase of the speed monitoring owned by neighbour logic [R1]
   always_comb begin
      if (sls_active) begin
         phase_in = ph_armed;
      end else if (sls_delay) begin
         phase_in = ph_delay;
      end else begin
         phase_in = ph_inactive;
      end
   end

   always_comb begin
      door_ev = 1'b0;
      esm_ev  = 1'b0;
      case (s.phase)
         ph_inactive: begin
            if (!syn.door_closed_input) begin
               door_ev = 1'b1; // [R7]
            end
         end
         ph_delay: begin
            // the switch is not looked at here [R8]
            if (!syn.door_closed_input) begin
               door_ev = 1'b1; // [R9]
            end
         end
         ph_armed: begin
            // switch ignored until the door has been seen open [R5]
            if (sls_active && door_fall && !syn.enabling_switch_input) begin
               door_ev = 1'b1; // [R4]
            end
         end
         ph_opened: begin
            if (sls_active && !syn.enabling_switch_input) begin
               esm_ev = 1'b1; // [R3] [R6]
            end
         end
         default: begin
            door_ev = 1'b1;
         end
      endcase
      if ((ss_rise || sls_rise) && !syn.door_closed_input) begin
         door_ev = 1'b1; // [R10] [R11]
      end
      if (ss_rise && !syn.speed_limit_request_input) begin
         esm_ev = 1'b1; // [R12]
      end
   end

   // a reset counts only when it raised no fault of its own
   assign reset_ok = (ss_rise || sls_rise) && !door_ev && !esm_ev && cfg_ok; // [R17]
   assign ev_vec   = {reset_ok, esm_ev, door_ev};

   always_comb begin
      next_s      = s;
      next_s.prev = syn;
      next_s.ack  = bus_go;

      // phase tracking; leaving monitoring drops the opened history
      if (phase_in != ph_armed) begin
         next_s.phase = phase_in;
      end else if (s.phase == ph_opened) begin
         next_s.phase = ph_opened; // [R6]
      end else if (!syn.door_closed_input && s.phase == ph_armed) begin
         next_s.phase = ph_opened; // [R5]
      end else begin
         next_s.phase = ph_armed;
      end

      // latched faults; a new fault beats a simultaneous reset
      if (reset_ok) begin
         next_s.door_flt = 1'b0;
         next_s.esm_flt  = 1'b0;
      end
      if (door_ev) begin
         next_s.door_flt = 1'b1; // [R17]
      end
      if (esm_ev) begin
         next_s.esm_flt = 1'b1; // [R17]
      end

      // door stays locked outside monitoring even under a fault
      next_s.unlock = sls_active && (s.phase == ph_armed || s.phase == ph_opened) &&
                      syn.enabling_switch_input && speed_below_limit; // [R2]

      // register reads
      next_s.rdata = 32'h0;
      if (bus_go && !wb_req.we) begin
         case (wb_req.adr)
            ADDR_CTRL: begin
               next_s.rdata[CFG_DOOR_LSB +: CFG_W] = s.door_cfg;
               next_s.rdata[CFG_ESM_LSB +: CFG_W]  = s.esm_cfg;
            end
            ADDR_STAT: begin
               next_s.rdata[EV_W-1:0] = s.stat;
            end
            ADDR_MASK: begin
               next_s.rdata[EV_W-1:0] = s.mask;
            end
            ADDR_STATE: begin
               next_s.rdata[STATE_PHASE_LSB +: 4] = s.phase;
               next_s.rdata[STATE_DFLT]           = s.door_flt;
               next_s.rdata[STATE_EFLT]           = s.esm_flt;
               next_s.rdata[STATE_UNLOCK]         = s.unlock;
               next_s.rdata[STATE_STOP]           = stop_request;
               next_s.rdata[STATE_CFGOK]          = cfg_ok;
            end
            default: begin
               next_s.rdata = 32'h0;
            end
         endcase
      end

      // register writes, low byte lane only
      if (bus_go && wb_req.we && wb_req.sel[0]) begin
         case (wb_req.adr)
            ADDR_CTRL: begin
               next_s.door_cfg = sdm_chan_cfg_t'(wb_req.dat[CFG_DOOR_LSB +: CFG_W]); // [R13]
               next_s.esm_cfg  = sdm_chan_cfg_t'(wb_req.dat[CFG_ESM_LSB +: CFG_W]);  // [R14]
            end
            ADDR_STAT: begin
               next_s.stat = s.stat & ~wb_req.dat[EV_W-1:0];
            end
            ADDR_MASK: begin
               next_s.mask = wb_req.dat[EV_W-1:0];
            end
            default: begin
               next_s.mask = next_s.mask;
            end
         endcase
      end
      // hardware set wins over a write-one clear in the same cycle
      next_s.stat = next_s.stat | ev_vec;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s.phase    <= ph_inactive;
         s.prev     <= PINS_RST;
         s.door_flt <= 1'b0;
         s.esm_flt  <= 1'b0;
         s.unlock   <= 1'b0;
         s.door_cfg <= sdm_chan_cfg_t'(CFG_RST);
         s.esm_cfg  <= sdm_chan_cfg_t'(CFG_RST);
         s.stat     <= 3'h0;
         s.mask     <= MASK_RST;
         s.ack      <= 1'b0;
         s.rdata    <= 32'h0;
      end else begin
         s <= next_s;
      end
   end

   assign wb_ack                = s.ack;
   assign wb_dat_o              = s.rdata;
   assign door_unlock           = s.unlock;
   assign door_fault            = s.door_flt;
   assign enabling_switch_fault = s.esm_flt;
   // an unusable configuration holds the stop as well [R13] [R14]
   assign stop_request          = s.door_flt || s.esm_flt || !cfg_ok; // [R17]
   assign irq                   = |(s.stat & s.mask);

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   property p_unlock_cause;
      door_unlock |-> $past(syn.enabling_switch_input && speed_below_limit && sls_active);
   endproperty
   a_unlock_cause: assert property (p_unlock_cause) else $error("unlock without cause"); // [R2]

   property p_esm_after_open;
      (s.phase == ph_opened && sls_active && !syn.enabling_switch_input) |=> s.esm_flt;
   endproperty
   a_esm_after_open: assert property (p_esm_after_open) else $error("switch fault missed"); // [R3]

   property p_door_open_no_esm;
      (s.phase == ph_armed && sls_active && door_fall && !syn.enabling_switch_input)
         |=> s.door_flt;
   endproperty
   a_door_open_no_esm: assert property (p_door_open_no_esm) else $error("door fault missed"); // [R4]

   property p_esm_ignored;
      (s.phase == ph_armed && !ss_rise && !s.esm_flt) |=> !s.esm_flt;
   endproperty
   a_esm_ignored: assert property (p_esm_ignored) else $error("switch seen too early"); // [R5]

   property p_opened_sticks;
      (s.phase == ph_opened && sls_active) |=> s.phase == ph_opened;
   endproperty
   a_opened_sticks: assert property (p_opened_sticks) else $error("opened phase lost"); // [R6]

   property p_inactive_door;
      (s.phase == ph_inactive && !syn.door_closed_input) |=> s.door_flt ##1 stop_request;
   endproperty
   a_inactive_door: assert property (p_inactive_door) else $error("inactive door fault missed"); // [R7]

   property p_delay_door;
      (s.phase == ph_delay && !syn.door_closed_input) |=> s.door_flt;
   endproperty
   a_delay_door: assert property (p_delay_door) else $error("delay door fault missed"); // [R9]

   property p_delay_esm;
      (s.phase == ph_delay && !ss_rise && !s.esm_flt) |=> !s.esm_flt;
   endproperty
   a_delay_esm: assert property (p_delay_esm) else $error("switch acted in delay"); // [R8]

   property p_reset_door_open;
      ((ss_rise || sls_rise) && !syn.door_closed_input) |=> s.door_flt && stop_request;
   endproperty
   a_reset_door_open: assert property (p_reset_door_open) else $error("reset door fault"); // [R10] [R11]

   property p_ss_reset_no_req;
      (ss_rise && !syn.speed_limit_request_input) |=> s.esm_flt;
   endproperty
   a_ss_reset_no_req: assert property (p_ss_reset_no_req) else $error("reset switch fault"); // [R12]

   property p_fault_clear;
      $fell(s.door_flt || s.esm_flt) |-> $past(reset_ok);
   endproperty
   a_fault_clear: assert property (p_fault_clear) else $error("fault cleared without reset"); // [R17]

   property p_cfg_stop;
      !cfg_ok |-> stop_request;
   endproperty
   a_cfg_stop: assert property (p_cfg_stop) else $error("stop not held on bad config"); // [R13] [R14]

   property p_wb_ack;
      bus_go |=> wb_ack ##1 !wb_ack;
   endproperty
   a_wb_ack: assert property (p_wb_ack) else $error("wishbone ack timing");

   property p_unlock_idle;
      !sls_active |=> !door_unlock;
   endproperty
   a_unlock_idle: assert property (p_unlock_idle) else $error("unlock outside monitoring"); // [R2]

   property p_door_event;
      door_ev |=> s.stat[EV_DOOR];
   endproperty
   a_door_event: assert property (p_door_event) else $error("door event not recorded"); // [R17]

   property p_esm_event;
      esm_ev |=> s.stat[EV_ESM];
   endproperty
   a_esm_event: assert property (p_esm_event) else $error("switch event not recorded"); // [R17]

   c_unlock: cover property (sls_active ##1 door_unlock);
   c_opened_close: cover property (s.phase == ph_opened && syn.door_closed_input);
   c_esm_fault: cover property ($rose(s.esm_flt));
   c_reset_ok: cover property (reset_ok);
endmodule // sdm_monitor

// ==== verif/sdm_op_model.sv ====
// far-side model: door switch, enabling switch, reset and request inputs
// assumes the bench says which levels the operator wants; pins move just after a clock edge
`timescale 1ns/1ns
module sdm_op_model
   import sdm_pkg::*;
(
   input  wire logic      clock,
   input  wire sdm_pins_t want,
   input  wire logic      overspeed,
   output sdm_pins_t      pins,
   output logic           speed_below_limit
);
   // pins take the levels the bench wants one clock later; the model adds no operator behaviour of its own
   always_ff @(posedge clock) begin
      pins <= want;
   end
   // speed kept under the limit unless the bench injects an overspeed
   assign speed_below_limit = !overspeed;
endmodule // sdm_op_model

// ==== verif/test_sdm_monitor.sv ====
// self-checking bench of the door and enabling-switch monitor
// assumes one 100 MHz clock; pin effects settle within the fixed sync and fault latency
`timescale 1ns/1ns
module test_sdm_monitor;
   import sdm_pkg::*;
   logic        clock;
   logic        rst_n;
   sdm_pins_t   want;
   sdm_pins_t   pins;
   logic        sls_active;
   logic        sls_delay;
   logic        overspeed;
   logic        speed_below_limit;
   sdm_wb_req_t wb_req;
   logic        wb_ack;
   logic [31:0] wb_dat_o;
   logic        door_unlock;
   logic        stop_request;
   logic        door_fault;
   logic        enabling_switch_fault;
   logic        irq;
   logic [31:0] q;
   int          errors;
   int          n_tests;

   sdm_op_model u_op (.clock(clock), .want(want), .overspeed(overspeed), .pins(pins),
                      .speed_below_limit(speed_below_limit));
   sdm_monitor u_dut (.clock(clock), .rst_n(rst_n), .pins(pins), .sls_active(sls_active),
                      .sls_delay(sls_delay), .speed_below_limit(speed_below_limit),
                      .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat_o(wb_dat_o),
                      .door_unlock(door_unlock), .stop_request(stop_request),
                      .door_fault(door_fault),
                      .enabling_switch_fault(enabling_switch_fault), .irq(irq));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic complete_run();
      if (errors == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask

   // master holds the request until ack is sampled high, then releases
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      wb_req <= '{1'b1, 1'b1, we, 4'hf, a, d};
      do begin
         @(posedge clock);
         n++;
      end while (wb_ack !== 1'b1 && n < 50);
      q = wb_dat_o;
      wb_req <= '0;
      if (n >= 50) begin
         errors++;
         complete_run();
      end
   endtask

   // pin levels {door, switch, request, stop}, then let sync and fault latency pass
   task automatic drv(input logic [3:0] p, input logic a, input logic d);
      @(posedge clock);
      want <= p;
      sls_active <= a;
      sls_delay <= d;
      repeat (8) @(posedge clock);
   endtask

   task automatic flt(input logic [1:0] e);
      chk("faults", {30'h0, e}, {30'h0, door_fault, enabling_switch_fault});
   endtask

   task automatic clr();
      drv(4'hc, 1'b0, 1'b0);
      drv(4'he, 1'b0, 1'b0);
      wb(1'b0, ADDR_STAT, 32'h0);
      chk("reset event", 32'h1, {31'h0, q[EV_RESET]});
      wb(1'b1, ADDR_STAT, 32'h7);
      drv(4'ha, 1'b0, 1'b0);
      flt(2'b00);
      chk("irq", 32'h0, {31'h0, irq});
   endtask

   task automatic s_regs();
      wb(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl", 32'h0, q);
      chk("stop", 32'h1, {31'h0, stop_request});
      flt(2'b00);
      wb(1'b1, 4'h2, 32'hff);
      wb(1'b0, 4'h2, 32'h0);
      chk("unmapped", 32'h0, q);
      for (int c = 0; c < 7; c++) begin
         wb(1'b1, ADDR_CTRL, {25'h0, 3'h1, 1'b0, c[2:0]});
         chk("door cfg stop", {31'h0, c == 0}, {31'h0, stop_request});
         wb(1'b1, ADDR_CTRL, {25'h0, c[2:0], 1'b0, 3'h1});
         chk("esm cfg stop", {31'h0, c == 0}, {31'h0, stop_request});
      end
      wb(1'b1, ADDR_CTRL, 32'h61);
      wb(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl", 32'h61, q);
      wb(1'b1, ADDR_MASK, 32'h7);
   endtask

   task automatic s_access();
      drv(4'h8, 1'b0, 1'b1);
      drv(4'hc, 1'b0, 1'b1);
      drv(4'h8, 1'b0, 1'b1);
      flt(2'b00);
      drv(4'h8, 1'b1, 1'b0);
      chk("unlock", 32'h0, {31'h0, door_unlock});
      drv(4'hc, 1'b1, 1'b0);
      drv(4'h8, 1'b1, 1'b0);
      flt(2'b00);
      drv(4'hc, 1'b1, 1'b0);
      chk("unlock", 32'h1, {31'h0, door_unlock});
      wb(1'b0, ADDR_STATE, 32'h0);
      chk("state", 32'h144, q);
      overspeed <= 1'b1;
      repeat (4) @(posedge clock);
      chk("unlock", 32'h0, {31'h0, door_unlock});
      overspeed <= 1'b0;
      drv(4'h4, 1'b1, 1'b0);
      drv(4'hc, 1'b1, 1'b0);
      flt(2'b00);
      drv(4'h8, 1'b1, 1'b0);
      flt(2'b01);
      chk("stop", 32'h1, {31'h0, stop_request});
      chk("irq", 32'h1, {31'h0, irq});
      drv(4'hc, 1'b1, 1'b0);
      flt(2'b01);
      clr();
   endtask

   task automatic s_door();
      drv(4'h8, 1'b1, 1'b0);
      drv(4'h0, 1'b1, 1'b0);
      flt(2'b11);
      clr();
      wb(1'b1, ADDR_MASK, 32'h0);
      drv(4'h2, 1'b0, 1'b0);
      flt(2'b10);
      chk("irq masked", 32'h0, {31'h0, irq});
      wb(1'b1, ADDR_MASK, 32'h7);
      chk("irq", 32'h1, {31'h0, irq});
      clr();
      drv(4'h8, 1'b0, 1'b1);
      drv(4'h0, 1'b0, 1'b1);
      flt(2'b10);
      clr();
   endtask

   task automatic s_resets();
      drv(4'he, 1'b1, 1'b0);
      drv(4'h6, 1'b1, 1'b0);
      flt(2'b00);
      drv(4'h7, 1'b1, 1'b0);
      flt(2'b10);
      clr();
      drv(4'hc, 1'b1, 1'b0);
      drv(4'h4, 1'b1, 1'b0);
      drv(4'h6, 1'b1, 1'b0);
      flt(2'b10);
      clr();
      drv(4'h8, 1'b0, 1'b0);
      drv(4'h9, 1'b0, 1'b0);
      flt(2'b01);
      clr();
   endtask

   initial begin
      errors = 0;
      n_tests = 0;
      rst_n = 1'b0;
      want = 4'ha;
      sls_active = 1'b0;
      sls_delay = 1'b0;
      overspeed = 1'b0;
      wb_req = '0;
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      s_regs();
      s_access();
      s_door();
      s_resets();
      complete_run();
   end
endmodule // test_sdm_monitor
